// File: hw/hv_setpoint_control_interface.sv
`include "hv_cfg.svh"

module hv_setpoint_control_interface
    import hv_pkg::*;
#(
    parameter int MIN_CYC = `US_CYC_UP(`PULSE_MIN_US),
    parameter int LO_CYC  = `US_CYC_UP(`PULSE_LO_US),
    parameter int HI_CYC  = `US_CYC_UP(`PULSE_HI_US),
    parameter int MAX_CYC = `US_CYC_DN(`PULSE_MAX_US)
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              link_clk,
    input  wire logic              sig1_in,
    input  wire logic              sig2_in,
    input  wire logic              en_n_in,
    input  wire logic              jumper_12_in,
    input  wire logic              jumper_23_in,
    input  wire logic              jumper_34_in,
    output logic      [`CODE_W-1:0] setpoint_a_r,
    output logic      [`CODE_W-1:0] setpoint_b_r,
    output ctrl_mode_t             mode_r,
    output logic                   sda_out_r,
    output logic                   sda_oe_n_r
);

    localparam int CW = `CODE_W;

    // core-side toggle, read back by the link synchroniser below
    logic          ack_tog_r;
    logic          ack_tog_nxt;

    // ============================================================
    // link domain: pin synchronisers and reset
    logic       rst_l_m_r;
    logic       rst_l_n_r;
    logic       sda_m_r;
    logic       sda_s_r;
    logic       sda_d_r;
    logic       scl_m_r;
    logic       scl_s_r;
    logic       scl_d_r;
    logic [1:0] jmp_l_m_r;
    logic [1:0] jmp_l_s_r;
    logic       ack_m_r;
    logic       ack_s_r;

    always_ff @(posedge link_clk) begin
        rst_l_m_r <= nrst;
        rst_l_n_r <= rst_l_m_r;
        sda_m_r   <= sig1_in;
        sda_s_r   <= sda_m_r;
        sda_d_r   <= sda_s_r;
        scl_m_r   <= sig2_in;
        scl_s_r   <= scl_m_r;
        scl_d_r   <= scl_s_r;
        jmp_l_m_r <= {jumper_12_in, jumper_34_in};
        jmp_l_s_r <= jmp_l_m_r;
        ack_m_r   <= ack_tog_r;
        ack_s_r   <= ack_m_r;
    end

    // ============================================================
    // link domain: i2c slave
    i2c_state_t     st_r;
    i2c_state_t     st_nxt;
    logic [2:0]     bitc_r;
    logic [2:0]     bitc_nxt;
    logic [7:0]     shreg_r;
    logic [7:0]     shreg_nxt;
    logic [2:0]     bytec_r;
    logic [2:0]     bytec_nxt;
    logic [3:0][7:0] rx_r;
    logic [3:0][7:0] rx_nxt;
    logic           rd_r;
    logic           rd_nxt;
    logic           wr_r;
    logic           wr_nxt;
    logic           ack_r;
    logic           ack_nxt;
    logic           ovf_r;
    logic           ovf_nxt;
    logic           oe_n_nxt;
    logic [CW-1:0]  hold_a_r;
    logic [CW-1:0]  hold_a_nxt;
    logic [CW-1:0]  hold_b_r;
    logic [CW-1:0]  hold_b_nxt;
    logic           req_tog_r;
    logic           req_tog_nxt;
    logic           scl_rise;
    logic           scl_fall;
    logic           start_c;
    logic           stop_c;
    logic           i2c_on;
    logic           mode12_s;
    logic [2:0]     exp_bytes;
    logic [7:0]     tx_byte;
    logic [7:0]     in_byte;

    always_comb begin
        // sampled at several link clocks per bit, see the clock ratio
        scl_rise  = scl_s_r & ~scl_d_r;
        scl_fall  = ~scl_s_r & scl_d_r;
        start_c   = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
        stop_c    = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
        i2c_on    = jmp_l_s_r[0];
        mode12_s  = jmp_l_s_r[1] & jmp_l_s_r[0];
        exp_bytes = mode12_s ? `BYTES_12BIT : `BYTES_8BIT;
        tx_byte   = mode12_s ? `MODE_BYTE_12 : `MODE_BYTE_8;
        in_byte   = {shreg_r[6:0], sda_s_r};
        st_nxt      = st_r;
        bitc_nxt    = bitc_r;
        shreg_nxt   = shreg_r;
        bytec_nxt   = bytec_r;
        rx_nxt      = rx_r;
        rd_nxt      = rd_r;
        wr_nxt      = wr_r;
        ack_nxt     = ack_r;
        ovf_nxt     = ovf_r;
        oe_n_nxt    = sda_oe_n_r;
        hold_a_nxt  = hold_a_r;
        hold_b_nxt  = hold_b_r;
        req_tog_nxt = req_tog_r;
        if (start_c) begin
            st_nxt    = ST_ADDR;
            bitc_nxt  = 3'h0;
            bytec_nxt = 3'h0;
            wr_nxt    = 1'b0;
            rd_nxt    = 1'b0;
            ovf_nxt   = 1'b0;
            oe_n_nxt  = 1'b1;
        end else if (stop_c) begin
            // a write landing while the last is still crossing is lost
            if (wr_r && !ovf_r && bytec_r == exp_bytes
                && req_tog_r == ack_s_r) begin
                if (mode12_s) begin
                    hold_a_nxt = {rx_r[0][3:0], rx_r[1]};
                    hold_b_nxt = {rx_r[2][3:0], rx_r[3]};
                end else begin
                    hold_a_nxt = {rx_r[0], 4'h0};
                    hold_b_nxt = {rx_r[1], 4'h0};
                end
                req_tog_nxt = ~req_tog_r;
            end
            st_nxt   = ST_IDLE;
            wr_nxt   = 1'b0;
            oe_n_nxt = 1'b1;
        end else begin
            unique case (st_r)
                ST_IDLE, ST_IGN: begin
                    oe_n_nxt = 1'b1;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shreg_nxt = in_byte;
                        bitc_nxt  = bitc_r + 3'h1;
                        if (bitc_r == 3'h7) begin
                            if (i2c_on && shreg_r[6:0] == `I2C_ADDR) begin
                                ack_nxt = 1'b1;
                                rd_nxt  = sda_s_r;
                                wr_nxt  = ~sda_s_r;
                                st_nxt  = ST_ACK1;
                            end else begin
                                st_nxt = ST_IGN;
                            end
                        end
                    end
                end
                ST_ACK1: begin
                    if (scl_fall) begin
                        oe_n_nxt = ~ack_r;
                        st_nxt   = ST_ACK2;
                    end
                end
                ST_ACK2: begin
                    if (scl_fall) begin
                        bitc_nxt = 3'h0;
                        if (rd_r) begin
                            oe_n_nxt = tx_byte[7];
                            st_nxt   = ST_RD;
                        end else begin
                            oe_n_nxt = 1'b1;
                            st_nxt   = ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        shreg_nxt = in_byte;
                        bitc_nxt  = bitc_r + 3'h1;
                        if (bitc_r == 3'h7) begin
                            if (bytec_r < exp_bytes) begin
                                rx_nxt[bytec_r[1:0]] = in_byte;
                                bytec_nxt = bytec_r + 3'h1;
                                ack_nxt   = 1'b1;
                            end else begin
                                ack_nxt = 1'b0;
                                ovf_nxt = 1'b1;
                            end
                            st_nxt = ST_ACK1;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bitc_nxt = bitc_r + 3'h1;
                        if (bitc_r == 3'h7) begin
                            st_nxt = ST_RACK;
                        end
                    end else if (scl_fall) begin
                        oe_n_nxt = tx_byte[3'h7 - bitc_r];
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        oe_n_nxt = 1'b1;
                    end else if (scl_rise) begin
                        st_nxt = ST_IGN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge link_clk) begin
        if (!rst_l_n_r) begin
            st_r       <= ST_IDLE;
            bitc_r     <= 3'h0;
            shreg_r    <= 8'h00;
            bytec_r    <= 3'h0;
            rx_r       <= '0;
            rd_r       <= 1'b0;
            wr_r       <= 1'b0;
            ack_r      <= 1'b0;
            ovf_r      <= 1'b0;
            sda_oe_n_r <= 1'b1;
            hold_a_r   <= '0;
            hold_b_r   <= '0;
            req_tog_r  <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            bitc_r     <= bitc_nxt;
            shreg_r    <= shreg_nxt;
            bytec_r    <= bytec_nxt;
            rx_r       <= rx_nxt;
            rd_r       <= rd_nxt;
            wr_r       <= wr_nxt;
            ack_r      <= ack_nxt;
            ovf_r      <= ovf_nxt;
            sda_oe_n_r <= oe_n_nxt;
            hold_a_r   <= hold_a_nxt;
            hold_b_r   <= hold_b_nxt;
            req_tog_r  <= req_tog_nxt;
        end
    end

    // ============================================================
    // core domain: synchronisers
    logic [5:0] pin_m_r;
    logic [5:0] pin_s_r;
    logic       req_m_r;
    logic       req_s_r;
    logic       req_d_r;

    always_ff @(posedge core_clk) begin
        pin_m_r <= {sig1_in, sig2_in, en_n_in,
                    jumper_12_in, jumper_23_in, jumper_34_in};
        pin_s_r <= pin_m_r;
        req_m_r <= req_tog_r;
        req_s_r <= req_m_r;
        req_d_r <= req_s_r;
    end

    // ============================================================
    // core domain: pwm decoders
    logic          pwm_on;
    logic [CW-1:0] pwm_code_a;
    logic [CW-1:0] pwm_code_b;
    logic          pwm_vld_a;
    logic          pwm_vld_b;

    assign pwm_on = (mode_r == MODE_PWM);

    pwm_width_decode #(
        .MIN_CYC (MIN_CYC),
        .LO_CYC  (LO_CYC),
        .HI_CYC  (HI_CYC),
        .MAX_CYC (MAX_CYC)
    ) u_pwm_a (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .pulse_in   (pin_s_r[5] & pwm_on),
        .code_r     (pwm_code_a),
        .code_vld_r (pwm_vld_a)
    );

    pwm_width_decode #(
        .MIN_CYC (MIN_CYC),
        .LO_CYC  (LO_CYC),
        .HI_CYC  (HI_CYC),
        .MAX_CYC (MAX_CYC)
    ) u_pwm_b (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .pulse_in   (pin_s_r[4] & pwm_on),
        .code_r     (pwm_code_b),
        .code_vld_r (pwm_vld_b)
    );

    // ============================================================
    // core domain: mode, setpoints, outputs
    logic          en_n_s;
    logic          req_edge;
    logic          i2c_mode;
    ctrl_mode_t    mode_nxt;
    logic [CW-1:0] sp_a_r;
    logic [CW-1:0] sp_a_nxt;
    logic [CW-1:0] sp_b_r;
    logic [CW-1:0] sp_b_nxt;
    logic [CW-1:0] out_a_nxt;
    logic [CW-1:0] out_b_nxt;

    always_comb begin
        en_n_s   = pin_s_r[3];
        req_edge = req_s_r ^ req_d_r;
        i2c_mode = (mode_r == MODE_I2C8) || (mode_r == MODE_I2C12);
        if (pin_s_r[2] && pin_s_r[0]) begin
            mode_nxt = MODE_I2C12;
        end else if (pin_s_r[0]) begin
            mode_nxt = MODE_I2C8;
        end else if (pin_s_r[1]) begin
            mode_nxt = MODE_PWM;
        end else begin
            mode_nxt = MODE_ANALOG;
        end
        sp_a_nxt    = sp_a_r;
        sp_b_nxt    = sp_b_r;
        ack_tog_nxt = ack_tog_r ^ req_edge;
        // hold words are stable here: the link waits for the ack
        if (req_edge && i2c_mode) begin
            sp_a_nxt = hold_a_r;
            sp_b_nxt = hold_b_r;
        end else if (pwm_on) begin
            if (pwm_vld_a) begin
                sp_a_nxt = pwm_code_a;
            end
            if (pwm_vld_b) begin
                sp_b_nxt = pwm_code_b;
            end
        end
        out_a_nxt = en_n_s ? '0 : sp_a_r;
        out_b_nxt = en_n_s ? '0 : sp_b_r;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_r       <= MODE_ANALOG;
            sp_a_r       <= '0;
            sp_b_r       <= '0;
            setpoint_a_r <= '0;
            setpoint_b_r <= '0;
            ack_tog_r    <= 1'b0;
            sda_out_r    <= 1'b0;
        end else begin
            mode_r       <= mode_nxt;
            sp_a_r       <= sp_a_nxt;
            sp_b_r       <= sp_b_nxt;
            setpoint_a_r <= out_a_nxt;
            setpoint_b_r <= out_b_nxt;
            ack_tog_r    <= ack_tog_nxt;
            sda_out_r    <= 1'b0;
        end
    end

    // ============================================================
    // checks
    sequence s_addr_byte;
        st_r == ST_ADDR && scl_rise && bitc_r == 3'h7;
    endsequence

    a_off_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        en_n_s |=> setpoint_a_r == '0 && setpoint_b_r == '0)
        else $error("outputs not zero while disabled");
    a_on_follow: assert property (@(posedge core_clk) disable iff (!nrst)
        !en_n_s |=> setpoint_a_r == $past(sp_a_r)
                    && setpoint_b_r == $past(sp_b_r))
        else $error("outputs not following setpoints");
    a_commit_take: assert property (@(posedge core_clk) disable iff (!nrst)
        req_edge && i2c_mode |=> sp_a_r == hold_a_r && sp_b_r == hold_b_r)
        else $error("i2c codes not applied together");
    a_foreign_addr: assert property (@(posedge link_clk)
        disable iff (!rst_l_n_r)
        s_addr_byte ##0 !(i2c_on && shreg_r[6:0] == `I2C_ADDR)
        |=> st_r == ST_IGN [*1] ##1 sda_oe_n_r)
        else $error("foreign address not ignored");
    a_ack_low: assert property (@(posedge link_clk)
        disable iff (!rst_l_n_r)
        st_r == ST_ACK1 && scl_fall && ack_r |=> !sda_oe_n_r)
        else $error("acknowledge not driven");
    a_mode_value: assert property (@(posedge link_clk)
        disable iff (!rst_l_n_r)
        st_r == ST_RD && scl_fall && bitc_r == 3'h7
        |=> sda_oe_n_r == !mode12_s)
        else $error("mode byte value wrong");
    a_one_byte: assert property (@(posedge link_clk)
        disable iff (!rst_l_n_r)
        st_r == ST_RACK && scl_rise |=> st_r == ST_IGN && sda_oe_n_r)
        else $error("read ran past one byte");
    a_short_write: assert property (@(posedge link_clk)
        disable iff (!rst_l_n_r)
        stop_c && wr_r && bytec_r != exp_bytes |=> $stable(req_tog_r))
        else $error("short write was applied");

endmodule

// File: hw/hv_cfg.svh
`ifndef HV_CFG_SVH
`define HV_CFG_SVH

// ============================================================
// clock and pulse timing
`define CORE_CLK_NS    10
`define PULSE_MIN_US   100
`define PULSE_LO_US    1000
`define PULSE_HI_US    2000
`define PULSE_MAX_US   5000
// least times round up, longest times round down
`define US_CYC_UP(us)  ((((us) * 1000) + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define US_CYC_DN(us)  (((us) * 1000) / `CORE_CLK_NS)
`define PWM_CNT_W      20
`define SCALE_SH       24

// ============================================================
// setpoint codes
`define CODE_W         12

// ============================================================
// i2c slave
`define I2C_ADDR       7'h78
`define MODE_BYTE_12   8'h00
`define MODE_BYTE_8    8'h01
`define BYTES_8BIT     3'h2
`define BYTES_12BIT    3'h4

`endif

// File: hw/hv_pkg.sv
package hv_pkg;

    typedef enum logic [1:0] {
        MODE_ANALOG,
        MODE_PWM,
        MODE_I2C8,
        MODE_I2C12
    } ctrl_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK1,
        ST_ACK2,
        ST_WR,
        ST_RD,
        ST_RACK,
        ST_IGN
    } i2c_state_t;

endpackage

// File: hw/pwm_width_decode.sv
`include "hv_cfg.svh"

module pwm_width_decode
    import hv_pkg::*;
#(
    parameter int CNT_W   = `PWM_CNT_W,
    parameter int CODE_W  = `CODE_W,
    parameter int MIN_CYC = `US_CYC_UP(`PULSE_MIN_US),
    parameter int LO_CYC  = `US_CYC_UP(`PULSE_LO_US),
    parameter int HI_CYC  = `US_CYC_UP(`PULSE_HI_US),
    parameter int MAX_CYC = `US_CYC_DN(`PULSE_MAX_US)
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              pulse_in,
    output logic      [CODE_W-1:0] code_r,
    output logic                   code_vld_r
);

    localparam int PW = CNT_W + CNT_W;
    localparam logic [CNT_W-1:0] MIN_C = CNT_W'(MIN_CYC);
    localparam logic [CNT_W-1:0] LO_C  = CNT_W'(LO_CYC);
    localparam logic [CNT_W-1:0] HI_C  = CNT_W'(HI_CYC);
    localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX_CYC);
    localparam logic [CNT_W-1:0] SAT_C = CNT_W'(MAX_CYC + 1);
    localparam logic [PW-1:0]    SPAN  = PW'(HI_CYC - LO_CYC);
    // reciprocal of the span, so no divider sits in the datapath
    localparam logic [PW-1:0]    SCALE =
        PW'((64'h1 << (CODE_W + `SCALE_SH)) / 64'(HI_CYC - LO_CYC));
    localparam logic [CODE_W-1:0] CODE_MAX = '1;

    logic              pulse_d_r;
    logic              pulse_d_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [CODE_W-1:0] code_nxt;
    logic              code_vld_nxt;
    logic              rise;
    logic              fall;
    logic [PW-1:0]     prod;
    logic [CODE_W:0]   quot;

    // ============================================================
    // width counter and mapping
    always_comb begin
        rise = pulse_in & ~pulse_d_r;
        fall = ~pulse_in & pulse_d_r;
        prod = PW'(cnt_r - LO_C) * SCALE;
        quot = prod[`SCALE_SH + CODE_W : `SCALE_SH];
        pulse_d_nxt  = pulse_in;
        cnt_nxt      = cnt_r;
        code_nxt     = code_r;
        code_vld_nxt = 1'b0;
        if (rise) begin
            cnt_nxt = CNT_W'(1);
        end else if (pulse_in && cnt_r != SAT_C) begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
        if (fall && cnt_r >= MIN_C && cnt_r <= MAX_C) begin
            code_vld_nxt = 1'b1;
            if (cnt_r <= LO_C) begin
                code_nxt = '0;
            end else if (cnt_r >= HI_C || quot[CODE_W]) begin
                code_nxt = CODE_MAX;
            end else begin
                code_nxt = quot[CODE_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pulse_d_r  <= 1'b0;
            cnt_r      <= '0;
            code_r     <= '0;
            code_vld_r <= 1'b0;
        end else begin
            pulse_d_r  <= pulse_d_nxt;
            cnt_r      <= cnt_nxt;
            code_r     <= code_nxt;
            code_vld_r <= code_vld_nxt;
        end
    end

    // ============================================================
    // checks
    logic [PW-1:0]     ref_full;
    logic [CODE_W-1:0] ref_code;
    assign ref_full = (PW'(cnt_r - LO_C) << CODE_W) / SPAN;
    assign ref_code = ref_full[CODE_W-1:0];

    sequence s_pulse_end;
        fall && cnt_r >= MIN_C && cnt_r <= MAX_C;
    endsequence

    a_short_drop: assert property (@(posedge core_clk) disable iff (!nrst)
        fall && cnt_r < MIN_C |=> !code_vld_r && $stable(code_r))
        else $error("short pulse changed the code");
    a_long_drop: assert property (@(posedge core_clk) disable iff (!nrst)
        fall && cnt_r > MAX_C |=> !code_vld_r && $stable(code_r))
        else $error("long pulse changed the code");
    a_low_clamp: assert property (@(posedge core_clk) disable iff (!nrst)
        s_pulse_end ##0 (cnt_r <= LO_C) |=> code_vld_r && code_r == '0)
        else $error("short valid pulse not clamped to minimum");
    a_high_clamp: assert property (@(posedge core_clk) disable iff (!nrst)
        s_pulse_end ##0 (cnt_r >= HI_C) |=> code_vld_r && code_r == CODE_MAX)
        else $error("long valid pulse not clamped to maximum");
    a_linear_map: assert property (@(posedge core_clk) disable iff (!nrst)
        s_pulse_end ##0 (cnt_r > LO_C && cnt_r < HI_C)
        |=> code_vld_r && code_r <= $past(ref_code)
            && code_r + CODE_W'(1) >= $past(ref_code))
        else $error("pulse width not mapped linearly");

endmodule

// File: tb/hv_master_model.sv
// ====
// far side: pwm pulse source and i2c bus master
module hv_master_model (
    input  wire logic       core_clk,
    input  wire logic       link_clk,
    input  wire logic       sda,
    output logic      [1:0] pwm,
    output logic            sda_m,
    output logic            scl
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pwm = 2'h0;
        sda_m = 1'b1;
        scl = 1'b1;
    end
    task automatic pulse(input logic ch, input int w);
        @(posedge core_clk);
        pwm[ch] <= 1'b1;
        repeat (w) @(posedge core_clk);
        pwm[ch] <= 1'b0;
        repeat (400) @(posedge core_clk);
    endtask
    // quarter bit: each scl phase spans 4 link cycles
    task automatic q();
        repeat (2) @(posedge link_clk);
    endtask
    task automatic start();
        sda_m <= 1'b1;
        scl <= 1'b1;
        q();
        sda_m <= 1'b0;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic bit_x(input logic b, output logic s);
        sda_m <= b;
        q();
        scl <= 1'b1;
        q();
        s = sda;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic byte_x(input logic [7:0] d, output logic [7:0] r,
                          output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(1'b1, ack);
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_m <= 1'b1;
        q();
    endtask
endmodule

// File: tb/hv_setpoint_control_interface_tb.sv
module hv_setpoint_control_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hv_pkg::*;
    logic        core_clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        en_n = 1'b0;
    logic        sel = 1'b0;
    logic [2:0]  jmp = 3'h0;
    logic [1:0]  pwm;
    logic        sda_m, scl, sda_oe_n_r, sda_out_r;
    logic [11:0] sp_a, sp_b;
    ctrl_mode_t  mode;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    wire logic   sda = sda_oe_n_r ? sda_m : sda_out_r;
    always #5 core_clk = ~core_clk;
    // odd start offset keeps the two clocks out of phase
    always begin
        #37;
        forever #80 link_clk = ~link_clk;
    end
    hv_setpoint_control_interface #(.MIN_CYC(10), .LO_CYC(100),
        .HI_CYC(200), .MAX_CYC(500)) i_dut (
        .core_clk(core_clk), .nrst(nrst), .link_clk(link_clk),
        .sig1_in(sel ? sda : pwm[0]), .sig2_in(sel ? scl : pwm[1]),
        .en_n_in(en_n), .jumper_12_in(jmp[2]), .jumper_23_in(jmp[1]),
        .jumper_34_in(jmp[0]), .setpoint_a_r(sp_a), .setpoint_b_r(sp_b),
        .mode_r(mode), .sda_out_r(sda_out_r), .sda_oe_n_r(sda_oe_n_r));
    hv_master_model i_mst (.core_clk(core_clk), .link_clk(link_clk),
        .sda(sda), .pwm(pwm), .sda_m(sda_m), .scl(scl));
    task automatic check(input string n, input logic [11:0] got,
                         input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic set_mode(input logic [2:0] j, input logic s,
                            input ctrl_mode_t m);
        @(posedge core_clk);
        jmp <= j;
        sel <= s;
        repeat (40) @(posedge core_clk);
        check("mode", 12'(mode), 12'(m));
    endtask
    // linear codes may land one below the exact floor
    task automatic pw(input logic ch, input int w, input logic [11:0] e);
        logic [11:0] g;
        i_mst.pulse(ch, w);
        g = ch ? sp_b : sp_a;
        if (e != 12'h000 && e != 12'hFFF && g === e - 12'h001) g = e;
        check("pwm", g, e);
    endtask
    task automatic rd(input logic [7:0] e);
        logic [7:0] r;
        logic       a;
        i_mst.start();
        i_mst.byte_x({7'h78, 1'b1}, r, a);
        check("rack", 12'(a), 12'h000);
        i_mst.byte_x(8'hFF, r, a);
        check("rbyte", 12'(r), 12'(e));
        i_mst.stop();
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                      input int n);
        logic [7:0] r;
        logic       a;
        i_mst.start();
        i_mst.byte_x(ad, r, a);
        check("wack", 12'(a), 12'(ad[7:1] != 7'h78));
        for (int i = 0; i < n; i++) i_mst.byte_x(d[31-8*i -: 8], r, a);
        i_mst.stop();
        repeat (60) @(posedge core_clk);
    endtask
    task automatic t_pwm();
        set_mode(3'h2, 1'b0, MODE_PWM);
        pw(1'b0, 150, 12'h800);
        pw(1'b0, 5, 12'h800);
        pw(1'b0, 600, 12'h800);
        pw(1'b0, 50, 12'h000);
        pw(1'b0, 300, 12'hFFF);
        pw(1'b1, 175, 12'hC00);
        en_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        check("en_off", sp_a, 12'h000);
        check("en_off_b", sp_b, 12'h000);
        en_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        check("en_on", sp_a, 12'hFFF);
        $display("t_pwm done");
    endtask
    task automatic t_i2c();
        set_mode(3'h1, 1'b1, MODE_I2C8);
        rd(8'h01);
        wr({7'h78, 1'b0}, 32'h1234_0000, 2);
        check("a8", sp_a, 12'h120);
        check("b8", sp_b, 12'h340);
        wr(8'hE0, 32'h5566_0000, 2);
        wr({7'h78, 1'b0}, 32'h7700_0000, 1);
        check("keep", sp_a, 12'h120);
        // one byte too many: the whole write must be thrown away
        wr({7'h78, 1'b0}, 32'h5566_7700, 3);
        check("long_a", sp_a, 12'h120);
        check("long_b", sp_b, 12'h340);
        set_mode(3'h5, 1'b1, MODE_I2C12);
        rd(8'h00);
        wr({7'h78, 1'b0}, 32'hA123_F456, 4);
        check("a12", sp_a, 12'h123);
        check("b12", sp_b, 12'h456);
        $display("t_i2c done");
    endtask
    // reset spans several link cycles for its two-flop crossing
    initial begin
        repeat (60) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (80) @(posedge core_clk);
        check("rst_a", sp_a, 12'h000);
        check("rst_b", sp_b, 12'h000);
        check("mode0", 12'(mode), 12'(MODE_ANALOG));
        t_pwm();
        t_i2c();
        finish_test();
    end
endmodule
